// ===== verilog/tms_pkg.sv
// shared constants and types for the temperature monitor register bank
package tms_pkg;

  ////////////////////////////////////////////////////////////////////////
  // command codes (register pointer values)
  localparam logic [7:0] TMS_CMD_REMOTE1_TEMP = 8'h01;
  localparam logic [7:0] TMS_CMD_REMOTE2_TEMP = 8'h02;
  localparam logic [7:0] TMS_CMD_REMOTE3_TEMP = 8'h03;
  localparam logic [7:0] TMS_CMD_REMOTE4_TEMP = 8'h04;
  localparam logic [7:0] TMS_CMD_LOCAL_TEMP = 8'h07;
  localparam logic [7:0] TMS_CMD_REMOTE1_FRAC = 8'h09;
  localparam logic [7:0] TMS_CMD_MAKER_CODE = 8'h0A;
  localparam logic [7:0] TMS_CMD_REMOTE1_WARN = 8'h11;
  localparam logic [7:0] TMS_CMD_REMOTE2_WARN = 8'h12;
  localparam logic [7:0] TMS_CMD_REMOTE3_WARN = 8'h13;
  localparam logic [7:0] TMS_CMD_REMOTE4_WARN = 8'h14;
  localparam logic [7:0] TMS_CMD_LOCAL_WARN = 8'h17;
  localparam logic [7:0] TMS_CMD_REMOTE1_CRIT = 8'h21;
  localparam logic [7:0] TMS_CMD_REMOTE4_CRIT = 8'h24;
  localparam logic [7:0] TMS_CMD_CONFIG1 = 8'h41;
  localparam logic [7:0] TMS_CMD_CONFIG2 = 8'h42;
  localparam logic [7:0] TMS_CMD_CONFIG3 = 8'h43;
  localparam logic [7:0] TMS_CMD_WARN_FLAGS = 8'h44;
  localparam logic [7:0] TMS_CMD_CRIT_FLAGS = 8'h45;
  localparam logic [7:0] TMS_CMD_FAULT_FLAGS = 8'h46;

  ////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] TMS_RST_ZERO = 8'h00;
  localparam logic [7:0] TMS_RST_REMOTE1_WARN = 8'h6E;
  localparam logic [7:0] TMS_RST_REMOTE2_WARN = 8'h7F;
  localparam logic [7:0] TMS_RST_REMOTE3_WARN = 8'h7F;
  localparam logic [7:0] TMS_RST_REMOTE4_WARN = 8'h64;
  localparam logic [7:0] TMS_RST_LOCAL_WARN = 8'h5A;
  localparam logic [7:0] TMS_RST_REMOTE1_CRIT = 8'h6E;
  localparam logic [7:0] TMS_RST_REMOTE4_CRIT = 8'h7F;
  // arbitrary neutral identification value
  localparam logic [7:0] TMS_MAKER_CODE_VAL = 8'h5C;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int TMS_WARN_LOCAL_BIT = 6;
  localparam int TMS_CFG1_STOP_BIT = 7;
  localparam int TMS_CFG1_SOFT_RST_BIT = 6;
  localparam int TMS_CFG3_CRIT1_MASK_BIT = 0;
  localparam int TMS_CFG3_CRIT4_MASK_BIT = 3;
  localparam int TMS_CRIT1_BIT = 0;
  localparam int TMS_CRIT4_BIT = 3;
  localparam logic [7:0] TMS_WARN_USED = 8'h4F;
  localparam logic [7:0] TMS_CRIT_USED = 8'h09;
  localparam logic [7:0] TMS_FAULT_USED = 8'h0F;
  // over-temperature hysteresis in degrees (one lsb is one degree)
  localparam logic [8:0] TMS_HYST_DEG = 9'h004;

  ////////////////////////////////////////////////////////////////////////
  // link operations and carriers
  typedef enum logic [1:0] {
    TMS_OP_SET_PTR,
    TMS_OP_WRITE,
    TMS_OP_READ,
    TMS_OP_ARA_DONE
  } tms_op_type;

  typedef struct packed {
    tms_op_type op;
    logic [7:0] data;
  } tms_link_req_type;

  typedef struct packed {
    logic [7:0] local_temp;
    logic [3:0][7:0] remote_temp;
    logic [7:0] remote1_frac;
    logic [3:0] diode_fault;
  } tms_conv_type;

endpackage

// ===== verilog/tms_toggle_sync.sv
// toggle-to-pulse synchroniser for one event crossing clock domains
`timescale 1ns/1ps
module tms_toggle_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tgl_i,
  output logic pulse_o
);

  logic meta;
  logic sync;
  logic last;

  // first stage feeds only the second one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= tgl_i;
      sync <= meta;
      last <= sync;
    end
  end

  assign pulse_o = sync ^ last;

endmodule

// ===== verilog/tms_crit_chan.sv
// over-temperature state of one channel with hysteresis release
`timescale 1ns/1ps
module tms_crit_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic conv_i,
  input wire logic [7:0] conv_temp_i,
  input wire logic [7:0] cur_temp_i,
  input wire logic [7:0] limit_i,
  input wire logic lim_wr_i,
  input wire logic [7:0] new_limit_i,
  output logic hot_o
);

  logic [8:0] conv_plus;
  logic [8:0] cur_plus;

  assign conv_plus = {1'b0, conv_temp_i} + tms_pkg::TMS_HYST_DEG;
  assign cur_plus = {1'b0, cur_temp_i} + tms_pkg::TMS_HYST_DEG;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hot_o <= 1'b0;
    end else if (conv_i && conv_temp_i > limit_i) begin
      hot_o <= 1'b1;
    end else if (conv_i && conv_plus < {1'b0, limit_i}) begin
      hot_o <= 1'b0;
    end else if (!conv_i && lim_wr_i && {1'b0, new_limit_i} >= cur_plus) begin
      hot_o <= 1'b0;
    end
  end

endmodule

// ===== verilog/tms_regs.sv
// register bank, status flags and alarm outputs of the temperature monitor
`timescale 1ns/1ps
module tms_regs (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic conv_done_i,
  input wire tms_pkg::tms_conv_type conv_i,
  input wire logic link_clk_i,
  input wire logic link_rst_i,
  input wire logic link_req_valid_i,
  input wire tms_pkg::tms_link_req_type link_req_i,
  output logic link_busy_o,
  output logic link_rd_valid_o,
  output logic [7:0] link_rd_data_o,
  output logic warn_irq_o,
  output logic crit_temp_out_o,
  output logic standby_o
);

  ////////////////////////////////////////////////////////////////////////
  // link domain: holds one request until the system side acknowledges

  tms_pkg::tms_link_req_type link_hold;
  logic link_req_tgl;
  logic link_ack_pulse;
  logic [7:0] sys_rsp_data;
  logic sys_ack_tgl;

  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      link_hold <= '0;
      link_req_tgl <= 1'b0;
      link_busy_o <= 1'b0;
    end else if (link_req_valid_i && !link_busy_o) begin
      link_hold <= link_req_i;
      link_req_tgl <= ~link_req_tgl;
      link_busy_o <= 1'b1;
    end else if (link_ack_pulse) begin
      link_busy_o <= 1'b0;
    end
  end

  // answer data is stable in the system domain before its toggle has crossed
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      link_rd_valid_o <= 1'b0;
      link_rd_data_o <= tms_pkg::TMS_RST_ZERO;
    end else begin
      link_rd_valid_o <= link_ack_pulse && link_hold.op == tms_pkg::TMS_OP_READ;
      if (link_ack_pulse) begin
        link_rd_data_o <= sys_rsp_data;
      end
    end
  end

  tms_toggle_sync u_ack_sync (
    .clk_i(link_clk_i),
    .rst_i(link_rst_i),
    .tgl_i(sys_ack_tgl),
    .pulse_o(link_ack_pulse)
  );

  ////////////////////////////////////////////////////////////////////////
  // system domain: request decode

  logic sys_req_pulse;
  logic op_set_ptr;
  logic op_write;
  logic op_read;
  logic op_ara;
  logic soft_rst;
  logic rst_all;

  tms_toggle_sync u_req_sync (
    .clk_i(clk_sys_i),
    .rst_i(sys_rst_i),
    .tgl_i(link_req_tgl),
    .pulse_o(sys_req_pulse)
  );

  // hold is only sampled after its toggle has crossed, so it is settled
  assign op_set_ptr = sys_req_pulse && link_hold.op == tms_pkg::TMS_OP_SET_PTR;
  assign op_write = sys_req_pulse && link_hold.op == tms_pkg::TMS_OP_WRITE;
  assign op_read = sys_req_pulse && link_hold.op == tms_pkg::TMS_OP_READ;
  assign op_ara = sys_req_pulse && link_hold.op == tms_pkg::TMS_OP_ARA_DONE;

  logic [7:0] cmd_ptr;

  // power-on bit of configuration one is never stored: it self-clears
  assign soft_rst = op_write && cmd_ptr == tms_pkg::TMS_CMD_CONFIG1 &&
    link_hold.data[tms_pkg::TMS_CFG1_SOFT_RST_BIT];
  assign rst_all = sys_rst_i || soft_rst;

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      cmd_ptr <= tms_pkg::TMS_RST_ZERO;
    end else if (op_set_ptr) begin
      cmd_ptr <= link_hold.data;
    end
  end

  function automatic logic wr_at(input logic [7:0] code);
    wr_at = op_write && cmd_ptr == code;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // temperature registers, loaded by the converter only

  logic [7:0] local_temp;
  logic [3:0][7:0] remote_temp;
  logic [7:0] remote1_temp_fraction;

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      local_temp <= tms_pkg::TMS_RST_ZERO;
      remote_temp <= '0;
      remote1_temp_fraction <= tms_pkg::TMS_RST_ZERO;
    end else if (conv_done_i) begin
      local_temp <= conv_i.local_temp;
      remote_temp <= conv_i.remote_temp;
      remote1_temp_fraction <= conv_i.remote1_frac;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // threshold registers

  logic [7:0] local_warn_limit;
  logic [3:0][7:0] remote_warn_limit;
  logic [7:0] remote1_crit_limit;
  logic [7:0] remote4_crit_limit;

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      local_warn_limit <= tms_pkg::TMS_RST_LOCAL_WARN;
      remote_warn_limit[0] <= tms_pkg::TMS_RST_REMOTE1_WARN;
      remote_warn_limit[1] <= tms_pkg::TMS_RST_REMOTE2_WARN;
      remote_warn_limit[2] <= tms_pkg::TMS_RST_REMOTE3_WARN;
      remote_warn_limit[3] <= tms_pkg::TMS_RST_REMOTE4_WARN;
    end else begin
      if (wr_at(tms_pkg::TMS_CMD_LOCAL_WARN)) begin
        local_warn_limit <= link_hold.data;
      end
      if (wr_at(tms_pkg::TMS_CMD_REMOTE1_WARN)) begin
        remote_warn_limit[0] <= link_hold.data;
      end
      if (wr_at(tms_pkg::TMS_CMD_REMOTE2_WARN)) begin
        remote_warn_limit[1] <= link_hold.data;
      end
      if (wr_at(tms_pkg::TMS_CMD_REMOTE3_WARN)) begin
        remote_warn_limit[2] <= link_hold.data;
      end
      if (wr_at(tms_pkg::TMS_CMD_REMOTE4_WARN)) begin
        remote_warn_limit[3] <= link_hold.data;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      remote1_crit_limit <= tms_pkg::TMS_RST_REMOTE1_CRIT;
      remote4_crit_limit <= tms_pkg::TMS_RST_REMOTE4_CRIT;
    end else begin
      if (wr_at(tms_pkg::TMS_CMD_REMOTE1_CRIT)) begin
        remote1_crit_limit <= link_hold.data;
      end
      if (wr_at(tms_pkg::TMS_CMD_REMOTE4_CRIT)) begin
        remote4_crit_limit <= link_hold.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0] configuration_1;
  logic [7:0] configuration_2;
  logic [7:0] configuration_3;

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      configuration_1 <= tms_pkg::TMS_RST_ZERO;
      configuration_2 <= tms_pkg::TMS_RST_ZERO;
      configuration_3 <= tms_pkg::TMS_RST_ZERO;
    end else begin
      if (wr_at(tms_pkg::TMS_CMD_CONFIG1)) begin
        configuration_1 <= link_hold.data;
      end
      if (wr_at(tms_pkg::TMS_CMD_CONFIG2)) begin
        configuration_2 <= link_hold.data;
      end
      if (wr_at(tms_pkg::TMS_CMD_CONFIG3)) begin
        configuration_3 <= link_hold.data;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      standby_o <= 1'b0;
    end else begin
      standby_o <= configuration_1[tms_pkg::TMS_CFG1_STOP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // warning flags and warning output

  logic [7:0] warn_flags;
  logic [7:0] warn_hit;
  logic [7:0] warn_mask;
  logic rd_warn;
  logic rd_crit;

  assign rd_warn = op_read && cmd_ptr == tms_pkg::TMS_CMD_WARN_FLAGS;
  assign rd_crit = op_read && cmd_ptr == tms_pkg::TMS_CMD_CRIT_FLAGS;

  always_comb begin
    warn_hit = '0;
    for (int i = 0; i < 4; i++) begin
      warn_hit[i] = conv_i.remote_temp[i] > remote_warn_limit[i];
    end
    warn_hit[tms_pkg::TMS_WARN_LOCAL_BIT] = conv_i.local_temp > local_warn_limit;
  end

  // mask bits sit at the same positions as the flags they gate
  assign warn_mask = configuration_2 & tms_pkg::TMS_WARN_USED;

  // a conversion landing on the clearing read wins over the clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      warn_flags <= tms_pkg::TMS_RST_ZERO;
    end else begin
      warn_flags <= ((rd_warn ? 8'h00 : warn_flags) |
        (conv_done_i ? warn_hit : 8'h00)) & tms_pkg::TMS_WARN_USED;
    end
  end

  // latched output: cleared by either event, raised again only by a conversion
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      warn_irq_o <= 1'b0;
    end else if (conv_done_i && |(warn_hit & ~warn_mask)) begin
      warn_irq_o <= 1'b1;
    end else if (rd_warn || op_ara) begin
      warn_irq_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // critical flags, hysteresis state and critical output

  logic [7:0] crit_flags;
  logic [7:0] crit_hit;
  logic crit1_hot;
  logic crit4_hot;

  always_comb begin
    crit_hit = '0;
    crit_hit[tms_pkg::TMS_CRIT1_BIT] = conv_i.remote_temp[0] > remote1_crit_limit;
    crit_hit[tms_pkg::TMS_CRIT4_BIT] = conv_i.remote_temp[3] > remote4_crit_limit;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      crit_flags <= tms_pkg::TMS_RST_ZERO;
    end else begin
      crit_flags <= ((rd_crit ? 8'h00 : crit_flags) |
        (conv_done_i ? crit_hit : 8'h00)) & tms_pkg::TMS_CRIT_USED;
    end
  end

  tms_crit_chan u_crit1 (
    .clk_i(clk_sys_i),
    .rst_i(rst_all),
    .conv_i(conv_done_i),
    .conv_temp_i(conv_i.remote_temp[0]),
    .cur_temp_i(remote_temp[0]),
    .limit_i(remote1_crit_limit),
    .lim_wr_i(wr_at(tms_pkg::TMS_CMD_REMOTE1_CRIT)),
    .new_limit_i(link_hold.data),
    .hot_o(crit1_hot)
  );

  tms_crit_chan u_crit4 (
    .clk_i(clk_sys_i),
    .rst_i(rst_all),
    .conv_i(conv_done_i),
    .conv_temp_i(conv_i.remote_temp[3]),
    .cur_temp_i(remote_temp[3]),
    .limit_i(remote4_crit_limit),
    .lim_wr_i(wr_at(tms_pkg::TMS_CMD_REMOTE4_CRIT)),
    .new_limit_i(link_hold.data),
    .hot_o(crit4_hot)
  );

  // no read term here: reading the flags leaves the output alone
  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      crit_temp_out_o <= 1'b0;
    end else begin
      crit_temp_out_o <=
        (crit1_hot && !configuration_3[tms_pkg::TMS_CFG3_CRIT1_MASK_BIT]) ||
        (crit4_hot && !configuration_3[tms_pkg::TMS_CFG3_CRIT4_MASK_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // diode fault flags, reflect the latest conversion

  logic [7:0] diode_fault_flags;

  always_ff @(posedge clk_sys_i) begin
    if (rst_all) begin
      diode_fault_flags <= tms_pkg::TMS_RST_ZERO;
    end else if (conv_done_i) begin
      diode_fault_flags <= {4'h0, conv_i.diode_fault} & tms_pkg::TMS_FAULT_USED;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read multiplexer and answer to the link

  logic [7:0] rd_value;

  always_comb begin
    case (cmd_ptr)
      tms_pkg::TMS_CMD_REMOTE1_TEMP: rd_value = remote_temp[0];
      tms_pkg::TMS_CMD_REMOTE2_TEMP: rd_value = remote_temp[1];
      tms_pkg::TMS_CMD_REMOTE3_TEMP: rd_value = remote_temp[2];
      tms_pkg::TMS_CMD_REMOTE4_TEMP: rd_value = remote_temp[3];
      tms_pkg::TMS_CMD_LOCAL_TEMP: rd_value = local_temp;
      tms_pkg::TMS_CMD_REMOTE1_FRAC: rd_value = remote1_temp_fraction;
      tms_pkg::TMS_CMD_MAKER_CODE: rd_value = tms_pkg::TMS_MAKER_CODE_VAL;
      tms_pkg::TMS_CMD_REMOTE1_WARN: rd_value = remote_warn_limit[0];
      tms_pkg::TMS_CMD_REMOTE2_WARN: rd_value = remote_warn_limit[1];
      tms_pkg::TMS_CMD_REMOTE3_WARN: rd_value = remote_warn_limit[2];
      tms_pkg::TMS_CMD_REMOTE4_WARN: rd_value = remote_warn_limit[3];
      tms_pkg::TMS_CMD_LOCAL_WARN: rd_value = local_warn_limit;
      tms_pkg::TMS_CMD_REMOTE1_CRIT: rd_value = remote1_crit_limit;
      tms_pkg::TMS_CMD_REMOTE4_CRIT: rd_value = remote4_crit_limit;
      tms_pkg::TMS_CMD_CONFIG1: rd_value = configuration_1;
      tms_pkg::TMS_CMD_CONFIG2: rd_value = configuration_2;
      tms_pkg::TMS_CMD_CONFIG3: rd_value = configuration_3;
      tms_pkg::TMS_CMD_WARN_FLAGS: rd_value = warn_flags;
      tms_pkg::TMS_CMD_CRIT_FLAGS: rd_value = crit_flags;
      tms_pkg::TMS_CMD_FAULT_FLAGS: rd_value = diode_fault_flags;
      default: rd_value = 8'h00;
    endcase
  end

  // value is captured on the same edge the ack toggle flips; the toggle's crossing delay lets the link see it settled
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sys_rsp_data <= tms_pkg::TMS_RST_ZERO;
      sys_ack_tgl <= 1'b0;
    end else if (sys_req_pulse) begin
      sys_rsp_data <= op_read ? rd_value : sys_rsp_data;
      sys_ack_tgl <= ~sys_ack_tgl;
    end
  end

endmodule

// ===== testbench/tms_regs_chk.sv
// port assertions of the temperature monitor register bank
`timescale 1ns/1ps
module tms_regs_chk (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic conv_done_i,
  input wire tms_pkg::tms_conv_type conv_i,
  input wire logic link_clk_i,
  input wire logic link_rst_i,
  input wire logic link_req_valid_i,
  input wire tms_pkg::tms_link_req_type link_req_i,
  input wire logic link_busy_o,
  input wire logic link_rd_valid_o,
  input wire logic [7:0] link_rd_data_o,
  input wire logic warn_irq_o,
  input wire logic crit_temp_out_o,
  input wire logic standby_o
);
  ////////////////
  warn_rise_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(warn_irq_o) |-> $past(conv_done_i)) else $error("warn rose off conversion");
  crit_rise_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(crit_temp_out_o) |-> $past(conv_done_i, 2)) else $error("crit rose off conversion");
  sys_reset_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> !warn_irq_o && !crit_temp_out_o && !standby_o)
    else $error("outputs not idle after reset");
  ////////////////
  // link side: the partner relies on busy to pace requests
  link_reset_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    $fell(link_rst_i) |-> !link_busy_o && !link_rd_valid_o) else $error("link not idle");
  req_taken_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    link_req_valid_i && !link_busy_o |=> link_busy_o) else $error("request not taken");
  busy_bound_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    $rose(link_busy_o) |-> ##[1:12] !link_busy_o) else $error("busy too long");
  rd_pulse_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    link_rd_valid_o |-> $fell(link_busy_o) ##1 !link_rd_valid_o) else $error("bad read pulse");
  rd_hold_a: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
    !link_rd_valid_o |-> $stable(link_rd_data_o)) else $error("read data moved");
endmodule
bind tms_regs tms_regs_chk u_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .conv_done_i(conv_done_i), .conv_i(conv_i), .link_clk_i(link_clk_i),
  .link_rst_i(link_rst_i), .link_req_valid_i(link_req_valid_i), .link_req_i(link_req_i),
  .link_busy_o(link_busy_o), .link_rd_valid_o(link_rd_valid_o),
  .link_rd_data_o(link_rd_data_o), .warn_irq_o(warn_irq_o),
  .crit_temp_out_o(crit_temp_out_o), .standby_o(standby_o));

// ===== testbench/tms_host_model.sv
// link-side host issuing pointer, write, read and alert-done requests
`timescale 1ns/1ps
module tms_host_model (
  input wire logic link_clk_i,
  input wire logic busy_i,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output logic valid_o,
  output tms_pkg::tms_link_req_type req_o
);
  initial begin
    valid_o = 1'b0;
    req_o = '0;
  end
  ////////////////
  // request held over the taking edge only; a hang returns unknown data
  task automatic xfer(input tms_pkg::tms_op_type op, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    @(negedge link_clk_i);
    valid_o = 1'b1;
    req_o = '{op: op, data: d};
    @(negedge link_clk_i);
    valid_o = 1'b0;
    req_o.data = ~d; // released byte never shows the old value
    do begin
      @(negedge link_clk_i);
      n++;
    end while (busy_i !== 1'b0 && n < 40);
    q = (rd_valid_i === 1'b1 && n < 40) ? rd_data_i : 8'hXX;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(tms_pkg::TMS_OP_SET_PTR, a, q);
    xfer(tms_pkg::TMS_OP_WRITE, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(tms_pkg::TMS_OP_SET_PTR, a, q);
    xfer(tms_pkg::TMS_OP_READ, 8'h00, q);
  endtask
  task automatic ara();
    logic [7:0] q;
    xfer(tms_pkg::TMS_OP_ARA_DONE, 8'h00, q);
  endtask
endmodule

// ===== testbench/tms_regs_tb.sv
// self-checking bench of the temperature monitor register bank
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tms_regs_tb;
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, lrst = 1'b1, cdone = 1'b0;
  logic busy, rdv, warn, crit, stby, valid, w;
  logic [7:0] rdd, q, a, d, e;
  tms_pkg::tms_conv_type conv = '0;
  tms_pkg::tms_link_req_type req;
  int err_total = 0, n_tests = 0, cyc = 0;
  logic [24:0] rows[31] = '{ // write flag, code, data, expected
    25'h0_01_00_00, 25'h0_02_00_00, 25'h0_03_00_00, 25'h0_04_00_00, 25'h0_07_00_00,
    25'h0_09_00_00, 25'h0_11_00_6E, 25'h0_12_00_7F, 25'h0_13_00_7F, 25'h0_14_00_64,
    25'h0_17_00_5A, 25'h0_21_00_6E, 25'h0_24_00_7F, 25'h0_41_00_00, 25'h0_42_00_00,
    25'h0_43_00_00, 25'h0_44_00_00, 25'h0_45_00_00, 25'h0_46_00_00, 25'h0_0A_00_5C,
    25'h1_11_55_55, 25'h1_11_6E_6E, 25'h1_24_7E_7E, 25'h1_24_7F_7F, 25'h1_42_A5_A5,
    25'h1_42_00_00, 25'h1_41_2C_2C, 25'h1_41_00_00, 25'h1_01_33_00, 25'h1_44_FF_00,
    25'h1_30_12_00};
  logic [15:0] temps[6] = '{16'h01_44, 16'h02_21, 16'h03_22, 16'h04_55, 16'h07_33, 16'h09_E0};
  tms_regs DUT (.clk_sys_i(clk), .sys_rst_i(rst), .conv_done_i(cdone), .conv_i(conv),
    .link_clk_i(lclk), .link_rst_i(lrst), .link_req_valid_i(valid), .link_req_i(req),
    .link_busy_o(busy), .link_rd_valid_o(rdv), .link_rd_data_o(rdd), .warn_irq_o(warn),
    .crit_temp_out_o(crit), .standby_o(stby));
  tms_host_model host (.link_clk_i(lclk), .busy_i(busy), .rd_valid_i(rdv),
    .rd_data_i(rdd), .valid_o(valid), .req_o(req));
  ////////////////
  initial forever #5 clk = ~clk;
  initial begin
    #7;
    forever #24 lclk = ~lclk;
  end
  // some hundred transfers of about twenty-five system cycles; generous margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // both domains held together; link needs four of its own edges
  task automatic rst_all();
    // off the system edge: a link negedge can share a time step with it
    @(negedge clk);
    rst = 1'b1;
    lrst = 1'b1;
    fork
      begin repeat (8) @(negedge clk); rst = 1'b0; end
      begin repeat (4) @(negedge lclk); lrst = 1'b0; end
    join
    repeat (4) @(negedge clk);
  endtask
  task automatic cv(input logic [7:0] lt, r1, r4, input logic [3:0] f);
    @(negedge clk);
    cdone = 1'b1;
    conv.local_temp = lt;
    conv.remote_temp = {r4, 8'h22, 8'h21, r1};
    conv.remote1_frac = 8'hE0;
    conv.diode_fault = f;
    @(negedge clk);
    cdone = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  ////////////////
  initial begin
    rst_all();
    foreach (rows[i]) begin
      {w, a, d, e} = rows[i];
      if (w) host.wr(a, d);
      host.rd(a, q);
      `CHK(q, e)
    end
    $display("test register map done");
    cv(8'h5B, 8'h6E, 8'h65, 4'h0);
    `CHK(warn, 1'b1)
    host.rd(8'h44, q);
    `CHK(q, 8'h48)
    `CHK(warn, 1'b0)
    host.rd(8'h44, q);
    `CHK(q, 8'h00)
    cv(8'h5B, 8'h6E, 8'h65, 4'h0);
    `CHK(warn, 1'b1)
    host.ara();
    `CHK(warn, 1'b0)
    host.wr(8'h17, 8'h5B);
    host.rd(8'h44, q);
    `CHK(q, 8'h48)
    cv(8'h5B, 8'h6E, 8'h65, 4'h0);
    host.rd(8'h44, q);
    `CHK(q, 8'h08)
    host.wr(8'h42, 8'h48);
    cv(8'h5C, 8'h00, 8'h65, 4'h0);
    `CHK(warn, 1'b0)
    host.rd(8'h44, q);
    `CHK(q, 8'h48)
    host.wr(8'h42, 8'h00);
    $display("test warning done");
    cv(8'h00, 8'h6F, 8'h00, 4'h0);
    `CHK(crit, 1'b1)
    host.rd(8'h45, q);
    `CHK(q, 8'h01)
    `CHK(crit, 1'b1)
    host.rd(8'h45, q);
    `CHK(q, 8'h00)
    cv(8'h00, 8'h6A, 8'h00, 4'h0);
    `CHK(crit, 1'b1)
    cv(8'h00, 8'h69, 8'h00, 4'h0);
    `CHK(crit, 1'b0)
    cv(8'h00, 8'h6F, 8'h00, 4'h0);
    cv(8'h00, 8'h6B, 8'h00, 4'h0);
    host.wr(8'h21, 8'h6E);
    `CHK(crit, 1'b1)
    host.wr(8'h21, 8'h6F);
    `CHK(crit, 1'b0)
    $display("test critical done");
    cv(8'h33, 8'h44, 8'h55, 4'hA);
    host.rd(8'h46, q);
    `CHK(q, 8'h0A)
    foreach (temps[i]) begin
      host.rd(temps[i][15:8], q);
      `CHK(q, temps[i][7:0])
    end
    $display("test conversion data done");
    host.wr(8'h43, 8'h01);
    cv(8'h00, 8'h70, 8'h00, 4'h0);
    `CHK(crit, 1'b0)
    host.wr(8'h41, 8'h80);
    `CHK(stby, 1'b1)
    host.wr(8'h41, 8'h40);
    `CHK(stby, 1'b0)
    host.rd(8'h43, q);
    `CHK(q, 8'h00)
    host.rd(8'h41, q);
    `CHK(q, 8'h00)
    host.rd(8'h21, q);
    `CHK(q, 8'h6E)
    host.rd(8'h01, q);
    `CHK(q, 8'h00)
    $display("test soft reset done");
    rst_all();
    host.xfer(tms_pkg::TMS_OP_READ, 8'h00, q);
    `CHK(q, 8'h00)
    host.rd(8'h21, q);
    `CHK(q, 8'h6E)
    `CHK(stby, 1'b0)
    $display("test mid-run reset done");
    close_out();
  end
endmodule
